// ### rtl/emb_bus_cycles.v
/*
 * External static memory bus cycle sequencer: drives address, data,
 * read and write strobes and chip selects through setup, strobe, hold
 * and dead-time phases counted in quarter system-clock ticks.
 * Assumes request and configuration inputs are synchronous to clock,
 * and that the memory meets the read access time given by the wait fields.
 */
`timescale 1ns/100ps
`include "emb_consts.vh"
module emb_bus_cycles
(
	input  wire                        clock,
	input  wire                        rst,
	input  wire                        reqValid,
	output wire                        reqReady,
	input  wire                        reqWrite,
	input  wire [`EMB_ADDR_W-1:0]      reqAddr,
	input  wire [`EMB_DATA_W-1:0]      reqData,
	input  wire [`EMB_CS_W-1:0]        reqChipSel,
	output reg  [`EMB_DATA_W-1:0]      rdData_r,
	output reg                         rdValid_r,
	input  wire [`EMB_WAIT_W-1:0]      storeWaitCount,
	input  wire [`EMB_WAIT_W-1:0]      storeSetupWait,
	input  wire [`EMB_WAIT_W-1:0]      storeHoldWait,
	input  wire [`EMB_WAIT_W-1:0]      readWaitCount,
	input  wire [`EMB_WAIT_W-1:0]      readSetupWait,
	input  wire [`EMB_WAIT_W-1:0]      readHoldWait,
	input  wire [`EMB_WAIT_W-1:0]      accessDeadtime,
	input  wire [`EMB_WAIT_W-1:0]      defaultAccessDeadtime,
	input  wire                        coreClockSourceSelect,
	input  wire                        prescalerDivOne,
	input  wire                        crystalInput,
	output reg  [`EMB_ADDR_W-1:0]      busAddr_r,
	output reg  [`EMB_DATA_W-1:0]      busDataOut_r,
	output reg                         busDataOe_r,
	input  wire [`EMB_DATA_W-1:0]      busDataIn,
	output reg                         readStrobeN_r,
	output reg                         writeStrobeN_r,
	output reg  [`EMB_CS_LINES-1:0]    chipSelN_r,
	output wire                        busBusy
);

	localparam [5:0] ST_IDLE   = 6'b000001;
	localparam [5:0] ST_START  = 6'b000010;
	localparam [5:0] ST_DEAD   = 6'b000100;
	localparam [5:0] ST_SETUP  = 6'b001000;
	localparam [5:0] ST_STROBE = 6'b010000;
	localparam [5:0] ST_HOLD   = 6'b100000;

	reg  [5:0]               state_r;
	reg  [5:0]               state_nxt;
	reg                      isWrite_r;
	reg  [`EMB_ADDR_W-1:0]   addr_r;
	reg  [`EMB_DATA_W-1:0]   data_r;
	reg  [`EMB_CS_W-1:0]     cs_r;
	reg  [`EMB_WAIT_W-1:0]   stWait_r;
	reg  [`EMB_WAIT_W-1:0]   stSetup_r;
	reg  [`EMB_WAIT_W-1:0]   stHold_r;
	reg  [`EMB_WAIT_W-1:0]   rdWait_r;
	reg  [`EMB_WAIT_W-1:0]   rdSetup_r;
	reg  [`EMB_WAIT_W-1:0]   rdHold_r;
	reg  [`EMB_WAIT_W-1:0]   dead_r;
	reg                      needDead_r;
	reg                      lastRead_r;
	reg  [`EMB_CS_W-1:0]     lastCs_r;
	reg                      timerLoad;
	reg  [`EMB_CNT_W-1:0]    timerValue;
	reg                      launch;
	reg                      enterStrobe;
	wire                     tick;
	wire                     timerDone;
	wire                     accept;
	wire                     chainOk;
	wire                     startNew;
	wire [`EMB_WAIT_W-1:0]   deadField;
	wire [`EMB_CNT_W-1:0]    setupQ;
	wire [`EMB_CNT_W-1:0]    strobeQ;
	wire [`EMB_CNT_W-1:0]    holdQ;
	wire [`EMB_CNT_W-1:0]    deadQ;
	wire [`EMB_CNT_W-1:0]    chainStrobeQ;

	// Wait field in quarter ticks
	function [`EMB_CNT_W-1:0] quarters;
		input [`EMB_WAIT_W-1:0] field;
		begin
			quarters = {1'b0, field, 2'b00};
		end
	endfunction

	// One-hot active-low select decode; select zero drives none
	function [`EMB_CS_LINES-1:0] csDecode;
		input [`EMB_CS_W-1:0] sel;
		integer i;
		begin
			csDecode = {`EMB_CS_LINES{1'b1}};
			for (i = 0; i < `EMB_CS_LINES; i = i + 1)
				if (sel == i[`EMB_CS_W-1:0] + 3'h1)
					csDecode[i] = 1'b0;
		end
	endfunction

	emb_quad_tick u_tick
	(
		.clock        (clock),
		.rst          (rst),
		.crystalInput (crystalInput),
		.bypassMode   (coreClockSourceSelect & prescalerDivOne),
		.tick         (tick)
	);

	emb_phase_timer #(.WIDTH(`EMB_CNT_W)) u_timer
	(
		.clock (clock),
		.rst   (rst),
		.load  (timerLoad),
		.value (timerValue),
		.tick  (tick),
		.done  (timerDone)
	);

	// Phase lengths from the fields latched at cycle start; the chained read strobe from readWaitCount as the request is taken
	assign setupQ = isWrite_r ?
		(((stWait_r == 5'h00) ? `EMB_WR_SETUP_BASE_Z : `EMB_WR_SETUP_BASE_NZ)
		+ quarters(stSetup_r)) :
		(`EMB_RD_SETUP_BASE + quarters(rdSetup_r));
	assign strobeQ = isWrite_r ?
		((stWait_r == 5'h00) ? `EMB_WR_STROBE_BASE_Z : {3'b000, stWait_r} * 8'h04) :
		(`EMB_RD_STROBE_BASE + quarters(rdWait_r));
	assign holdQ = isWrite_r ? (`EMB_WR_HOLD_BASE + quarters(stHold_r)) :
		(`EMB_RD_HOLD_BASE + quarters(rdHold_r));
	assign deadQ = quarters(dead_r);
	assign chainStrobeQ = `EMB_RD_STROBE_BASE + quarters(readWaitCount);

	// Unmapped accesses take the default dead time
	assign deadField = (reqChipSel == `EMB_CS_NONE) ? defaultAccessDeadtime : accessDeadtime;

	// Back-to-back reads on the same select keep the strobe low when the read setup and hold fields are zero
	assign chainOk = !isWrite_r && !reqWrite && (rdSetup_r == 5'h00) && (rdHold_r == 5'h00)
		&& (readSetupWait == 5'h00) && (reqChipSel == cs_r);
	assign reqReady = (state_r == ST_IDLE) || ((state_r == ST_STROBE) && timerDone && chainOk);
	assign accept = reqValid && reqReady;
	assign startNew = accept && (state_r == ST_IDLE);
	assign busBusy = (state_r != ST_IDLE);

	always @*
	begin
		state_nxt = state_r;
		timerLoad = 1'b0;
		timerValue = `EMB_CNT_RESET;
		launch = 1'b0;
		enterStrobe = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (startNew)
					state_nxt = ST_START;
			end
			ST_START:
			begin
				if (needDead_r)
				begin
					state_nxt = ST_DEAD;
					timerLoad = 1'b1;
					timerValue = deadQ;
				end
				else
					launch = 1'b1;
			end
			ST_DEAD:
			begin
				if (timerDone)
					launch = 1'b1;
			end
			ST_SETUP:
			begin
				if (timerDone)
					enterStrobe = 1'b1;
			end
			ST_STROBE:
			begin
				if (timerDone)
				begin
					if (accept)
					begin
						timerLoad = 1'b1;
						timerValue = chainStrobeQ;
					end
					else if (holdQ != `EMB_CNT_RESET)
					begin
						state_nxt = ST_HOLD;
						timerLoad = 1'b1;
						timerValue = holdQ;
					end
					else
						state_nxt = ST_IDLE;
				end
			end
			ST_HOLD:
			begin
				if (timerDone)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		if (launch)
		begin
			if (setupQ != `EMB_CNT_RESET)
			begin
				state_nxt = ST_SETUP;
				timerLoad = 1'b1;
				timerValue = setupQ;
			end
			else
				enterStrobe = 1'b1;
		end
		if (enterStrobe)
		begin
			state_nxt = ST_STROBE;
			timerLoad = 1'b1;
			timerValue = strobeQ;
		end
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			state_r        <= ST_IDLE;
			isWrite_r      <= 1'b0;
			addr_r         <= `EMB_ADDR_RESET;
			data_r         <= `EMB_DATA_RESET;
			cs_r           <= `EMB_CS_NONE;
			stWait_r       <= 5'h00;
			stSetup_r      <= 5'h00;
			stHold_r       <= 5'h00;
			rdWait_r       <= 5'h00;
			rdSetup_r      <= 5'h00;
			rdHold_r       <= 5'h00;
			dead_r         <= 5'h00;
			needDead_r     <= 1'b0;
			lastRead_r     <= 1'b0;
			lastCs_r       <= `EMB_CS_NONE;
			rdData_r       <= `EMB_DATA_RESET;
			rdValid_r      <= 1'b0;
			busAddr_r      <= `EMB_ADDR_RESET;
			busDataOut_r   <= `EMB_DATA_RESET;
			busDataOe_r    <= 1'b0;
			readStrobeN_r  <= 1'b1;
			writeStrobeN_r <= 1'b1;
			chipSelN_r     <= {`EMB_CS_LINES{1'b1}};
		end
		else
		begin
			state_r   <= state_nxt;
			rdValid_r <= 1'b0;
			// Fields are latched only when a cycle starts
			if (accept)
			begin
				isWrite_r  <= reqWrite;
				addr_r     <= reqAddr;
				data_r     <= reqData;
				cs_r       <= reqChipSel;
				stWait_r   <= storeWaitCount;
				stSetup_r  <= storeSetupWait;
				stHold_r   <= storeHoldWait;
				rdWait_r   <= readWaitCount;
				rdSetup_r  <= readSetupWait;
				rdHold_r   <= readHoldWait;
				dead_r     <= deadField;
				needDead_r <= lastRead_r && (reqChipSel != lastCs_r)
					&& (deadField != 5'h00);
			end
			// Address pins change only when a bus access drives them
			if (launch)
			begin
				busAddr_r    <= addr_r;
				chipSelN_r   <= csDecode(cs_r);
				busDataOut_r <= data_r;
				busDataOe_r  <= isWrite_r;
			end
			if (enterStrobe)
			begin
				readStrobeN_r  <= isWrite_r;
				writeStrobeN_r <= !isWrite_r;
			end
			if ((state_r == ST_STROBE) && timerDone)
			begin
				if (!isWrite_r)
				begin
					rdData_r  <= busDataIn;
					rdValid_r <= 1'b1;
				end
				if (accept)
					busAddr_r <= reqAddr;
				else
				begin
					readStrobeN_r  <= 1'b1;
					writeStrobeN_r <= 1'b1;
				end
			end
			// Data drive and select end together when the access ends; the address keeps its value
			if ((state_nxt == ST_IDLE) && (state_r != ST_IDLE))
			begin
				busDataOe_r <= 1'b0;
				chipSelN_r  <= {`EMB_CS_LINES{1'b1}};
				lastRead_r  <= !isWrite_r;
				lastCs_r    <= cs_r;
			end
		end
	end

endmodule // emb_bus_cycles

// ### rtl/emb_consts.vh
/*
 * Constants of the external static memory bus sequencer: reset values,
 * field widths and the quarter-clock phase counts of each bus phase.
 * Assumes one quadrature tick is one quarter of a system clock period.
 */
`ifndef EMB_CONSTS_VH
`define EMB_CONSTS_VH

// System clock period in ns
`define EMB_CLK_PERIOD_NS      5

// Widths
`define EMB_ADDR_W             16
`define EMB_DATA_W             16
`define EMB_WAIT_W             5
`define EMB_CS_W               3
`define EMB_CS_LINES           7
`define EMB_CNT_W              8

// Quadrature ticks in one system clock period
`define EMB_QUARTERS_PER_CLK   4

// Fixed phase portions, counted in quarter periods
`define EMB_WR_SETUP_BASE_Z    8'h02
`define EMB_WR_SETUP_BASE_NZ   8'h03
`define EMB_WR_STROBE_BASE_Z   8'h01
`define EMB_WR_HOLD_BASE       8'h01
`define EMB_RD_SETUP_BASE      8'h00
`define EMB_RD_STROBE_BASE     8'h04
`define EMB_RD_HOLD_BASE       8'h00

// Reset values
`define EMB_ADDR_RESET         16'h0000
`define EMB_DATA_RESET         16'h0000
`define EMB_CNT_RESET          8'h00
`define EMB_CS_NONE            3'h0

`endif

// ### rtl/emb_phase_timer.v
/*
 * Down counter timing one bus phase in quadrature ticks.
 * Assumes load is a one-cycle pulse and value is nonzero when loaded.
 */
`timescale 1ns/100ps
`include "emb_consts.vh"
module emb_phase_timer
#(
	parameter WIDTH = 8
)
(
	input  wire             clock,
	input  wire             rst,
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	input  wire             tick,
	output wire             done
);

	reg [WIDTH-1:0] count_r;

	always @(posedge clock)
	begin
		if (rst)
			count_r <= {WIDTH{1'b0}};
		else if (load)
			count_r <= value;
		else if (tick && (count_r != {WIDTH{1'b0}}))
			count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	assign done = tick && (count_r == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule // emb_phase_timer

// ### rtl/emb_quad_tick.v
/*
 * Quadrature tick generator for the bus sequencer.
 * Assumes crystalInput is synchronous to clock; in bypass mode each
 * crystal edge, rising or falling, is one quarter-period tick.
 */
`timescale 1ns/100ps
module emb_quad_tick
(
	input  wire clock,
	input  wire rst,
	input  wire crystalInput,
	input  wire bypassMode,
	output wire tick
);

	reg crystalLast_r;

	always @(posedge clock)
	begin
		if (rst)
			crystalLast_r <= 1'b0;
		else
			crystalLast_r <= crystalInput;
	end

	// Both crystal edges make ticks when the prescaler is bypassed
	assign tick = bypassMode ? (crystalInput ^ crystalLast_r) : 1'b1;

endmodule // emb_quad_tick

// ### test/emb_assertions.sv
/* Checker of the bus sequencer pin timing.
 Assumes a bind to emb_bus_cycles; ticks run every clock outside bypass. */
`timescale 1ns/100ps
`include "emb_consts.vh"
module emb_checker
(
	input wire                     clock,
	input wire                     rst,
	input wire                     reqValid,
	input wire                     reqReady,
	input wire                     busBusy,
	input wire [`EMB_WAIT_W-1:0]   storeWaitCount,
	input wire [`EMB_WAIT_W-1:0]   readWaitCount,
	input wire                     coreClockSourceSelect,
	input wire                     prescalerDivOne,
	input wire [`EMB_ADDR_W-1:0]   busAddr_r,
	input wire                     busDataOe_r,
	input wire [`EMB_DATA_W-1:0]   busDataIn,
	input wire [`EMB_DATA_W-1:0]   rdData_r,
	input wire                     rdValid_r,
	input wire                     readStrobeN_r,
	input wire                     writeStrobeN_r,
	input wire [`EMB_CS_LINES-1:0] chipSelN_r
);
	reg [`EMB_WAIT_W-1:0] wrWait_r;
	reg [`EMB_WAIT_W-1:0] rdWait_r;
	wire                  noBypass = !(coreClockSourceSelect && prescalerDivOne);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Wait fields as taken with the request
	always @(posedge clock)
		if (reqValid && reqReady)
		begin
			wrWait_r <= storeWaitCount;
			rdWait_r <= readWaitCount;
		end
	sequence s_wrLow4;
		!writeStrobeN_r [*4] ##1 writeStrobeN_r;
	endsequence
	sequence s_rdLow4;
		!readStrobeN_r [*4] ##1 rdValid_r;
	endsequence
	property p_idleAddr;
		!busBusy |-> $stable(busAddr_r);
	endproperty
	property p_dataLead;
		$fell(writeStrobeN_r) |-> busDataOe_r && $past(busDataOe_r);
	endproperty
	property p_wrHold;
		$rose(writeStrobeN_r) |-> busDataOe_r && $stable(busAddr_r);
	endproperty
	property p_wrZero;
		$fell(writeStrobeN_r) && noBypass && wrWait_r == 0 |=> writeStrobeN_r;
	endproperty
	property p_wrOne;
		$fell(writeStrobeN_r) && noBypass && wrWait_r == 1 |-> s_wrLow4;
	endproperty
	property p_rdWidth;
		$fell(readStrobeN_r) && noBypass && rdWait_r == 0 |-> s_rdLow4;
	endproperty
	property p_rdSample;
		$rose(readStrobeN_r) |-> rdValid_r && rdData_r == $past(busDataIn);
	endproperty
	property p_csSteady;
		!readStrobeN_r && !$past(readStrobeN_r) |-> $stable(chipSelN_r);
	endproperty
	a_idleAddr: assert property (p_idleAddr) else $error("address moved idle");
	a_dataLead: assert property (p_dataLead) else $error("data late");
	a_wrHold: assert property (p_wrHold) else $error("write hold short");
	a_wrZero: assert property (p_wrZero) else $error("write strobe long");
	a_wrOne: assert property (p_wrOne) else $error("write strobe width");
	a_rdWidth: assert property (p_rdWidth) else $error("read strobe width");
	a_rdSample: assert property (p_rdSample) else $error("read data lost");
	a_csSteady: assert property (p_csSteady) else $error("select moved");
endmodule // emb_checker
bind emb_bus_cycles emb_checker emb_checker_inst (.clock, .rst, .reqValid, .reqReady,
	.busBusy, .storeWaitCount, .readWaitCount, .coreClockSourceSelect, .prescalerDivOne,
	.busAddr_r, .busDataOe_r, .busDataIn, .rdData_r, .rdValid_r, .readStrobeN_r,
	.writeStrobeN_r, .chipSelN_r);

// ### test/emb_mem_model.sv
/* Asynchronous static memory on the bus pins.
 Assumes it answers every select; slow delays read data by two clocks. */
`timescale 1ns/100ps
module emb_mem_model
(
	input  wire        clock,
	input  wire        slow,
	input  wire        readStrobeN,
	input  wire        writeStrobeN,
	input  wire [15:0] busAddr,
	input  wire [15:0] busDataOut,
	input  wire        busDataOe,
	output wire [15:0] busDataIn
);
	reg [15:0] mem [0:255];
	reg [15:0] pat = 16'h5a5a;
	reg [15:0] lastAddr = 16'h0000;
	reg [1:0]  age = 2'h0;
	// Write lands on the trailing strobe edge
	always @(posedge writeStrobeN)
		if (busDataOe)
			mem[busAddr[7:0]] <= busDataOut;
	always @(posedge clock)
	begin
		pat <= ~pat;
		lastAddr <= busAddr;
		if (readStrobeN || busAddr != lastAddr)
			age <= 2'h0;
		else if (age != 2'h2)
			age <= age + 2'h1;
	end
	// Data valid inside the access window, a changing pattern otherwise
	assign busDataIn = (!readStrobeN && busAddr == lastAddr && (!slow || age == 2'h2))
		? mem[busAddr[7:0]] : pat;
endmodule // emb_mem_model

// ### test/test_emb_bus_cycles.sv
/* Testbench of the bus sequencer with a memory model.
 Assumes one tick per clock outside bypass. */
`timescale 1ns/100ps
module test_emb_bus_cycles;
	reg        clock = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
	reg        slow = 1'b0, core = 1'b0, pre = 1'b0, crystalInput = 1'b0;
	reg [15:0] reqAddr = 16'h0000, reqData = 16'h0000;
	reg [2:0]  reqChipSel = 3'h0;
	reg [4:0]  sw = 5'h00, ss = 5'h00, sh = 5'h00, rw = 5'h00, rs = 5'h00, rh = 5'h00;
	reg [4:0]  dt = 5'h02, ddt = 5'h01;
	reg        pS = 1'b1, pB = 1'b0;
	reg [15:0] shadow [0:255];
	wire       reqReady, busBusy, rdValid, busDataOe, rdN, wrN;
	wire [15:0] rdData, busAddr, busDataOut, busDataIn;
	wire [6:0] chipSelN;
	reg  [6:0] csSeen = 7'h7f;
	wire       st = rdN & wrN;
	integer    fails = 0, compares = 0, cyc = 0, tAcc = 0, tLo = 0, tHi = 0, tOff = 0;
	integer    nHi = 0, nV = 0, gap = 0, n0, v0;
	always #2.5 clock = ~clock;
	emb_bus_cycles emb_bus_cycles_inst
	(
		.clock, .rst, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .reqChipSel,
		.rdData_r(rdData), .rdValid_r(rdValid), .storeWaitCount(sw), .storeSetupWait(ss),
		.storeHoldWait(sh), .readWaitCount(rw), .readSetupWait(rs), .readHoldWait(rh),
		.accessDeadtime(dt), .defaultAccessDeadtime(ddt), .coreClockSourceSelect(core),
		.prescalerDivOne(pre), .crystalInput, .busAddr_r(busAddr), .busDataOut_r(busDataOut),
		.busDataOe_r(busDataOe), .busDataIn, .readStrobeN_r(rdN), .writeStrobeN_r(wrN),
		.chipSelN_r(chipSelN), .busBusy
	);
	emb_mem_model emb_mem_model_inst (.clock, .slow, .readStrobeN(rdN), .writeStrobeN(wrN),
		.busAddr, .busDataOut, .busDataOe, .busDataIn);
	// Event times of strobe edges, accept and end of access
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		crystalInput <= cyc[1];
		if (reqValid && reqReady) tAcc = cyc;
		if (pS && !st) tLo = cyc;
		if (!pS && st) tHi = cyc;
		if (!pS && st) nHi = nHi + 1;
		if (pB && !busBusy) tOff = cyc;
		if (rdValid) nV = nV + 1;
		if (!st) csSeen = chipSelN;
		pS = st;
		pB = busBusy;
	end
	task conclude;
		begin
			if (fails == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chkT(input ok);
		begin
			compares = compares + 1;
			if (ok !== 1'b1)
			begin
				fails = fails + 1;
				$display("wrong value at %0t: timing", $time);
			end
		end
	endtask
	task chkD(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp)
			begin
				fails = fails + 1;
				$display("wrong value at %0t: data %h", $time, got);
			end
		end
	endtask
	task cfg(input [4:0] a, b, c, d, e, f);
		begin
			@(posedge clock);
			{sw, ss, sh, rw, rs, rh} <= {a, b, c, d, e, f};
		end
	endtask
	// Waits for ready (bsy low) or for the end of the access (bsy high)
	task hold(input bsy);
		integer i;
		begin
			i = 0;
			@(negedge clock);
			while ((bsy ? busBusy : ~reqReady) !== 1'b0 && i < 400)
			begin
				@(negedge clock);
				i = i + 1;
			end
			if (i >= 400)
			begin
				fails = fails + 1;
				conclude;
			end
			else
				@(posedge clock);
		end
	endtask
	task run(input w, input [15:0] a, input [2:0] cs, input integer dead, k, chg);
		integer s, wd, h, h0;
		begin
			@(posedge clock);
			h0 = tHi;
			s = w ? (sw == 0 ? 2 : 3) + 4 * ss : 4 * rs;
			wd = w ? (sw == 0 ? 1 : 4 * sw) : 4 + 4 * rw;
			h = w ? 1 + 4 * sh : 4 * rh;
			reqValid <= 1'b1;
			reqWrite <= w;
			reqAddr <= a;
			reqData <= ~a;
			reqChipSel <= cs;
			hold(0);
			reqValid <= 1'b0;
			if (chg) rw <= ~rw;
			hold(1);
			if (chg) rw <= ~rw;
			@(negedge clock);
			gap = tLo - h0;
			if (k == 1) chkT(tLo - tAcc == 2 + 4 * dead + s);
			chkT(tHi - tLo == k * wd);
			chkT(tOff - tHi == k * h);
			chkD({9'h000, csSeen}, {9'h000, (cs == 3'h0) ? 7'h7f : ~(7'h01 << (cs - 3'h1))});
			if (w) shadow[a[7:0]] = ~a;
			else chkD(rdData, shadow[a[7:0]]);
		end
	endtask
	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		run(1, 16'h0010, 3'h1, 0, 1, 0);
		cfg(1, 1, 1, 0, 0, 0);
		run(1, 16'h0011, 3'h1, 0, 1, 0);
		run(1, 16'h0012, 3'h1, 0, 1, 0);
		chkT(gap >= 4 * 2 + 4);
		run(0, 16'h0010, 3'h1, 0, 1, 0);
		chkT(gap >= 4 * 1 + 1);
		cfg(0, 1, 0, 1, 0, 1);
		run(0, 16'h0011, 3'h1, 0, 1, 0);
		run(1, 16'h0013, 3'h2, 2, 1, 0);
		chkT(gap >= 4 * (1 + 1 + 2) + 2);
		cfg(0, 0, 0, 1, 1, 1);
		slow <= 1'b1;
		run(0, 16'h0012, 3'h2, 0, 1, 1);
		run(0, 16'h0013, 3'h0, 1, 1, 0);
		run(0, 16'h0010, 3'h0, 0, 1, 0);
		run(0, 16'h0011, 3'h3, 2, 1, 0);
		cfg(0, 0, 0, 0, 0, 0);
		n0 = nHi;
		v0 = nV;
		@(posedge clock);
		reqValid <= 1'b1;
		reqWrite <= 1'b0;
		reqAddr <= 16'h0012;
		reqChipSel <= 3'h1;
		hold(0);
		reqAddr <= 16'h0013;
		hold(0);
		reqValid <= 1'b0;
		hold(1);
		@(negedge clock);
		chkT(nHi == n0 + 1 && nV == v0 + 2);
		chkD(rdData, shadow[8'h13]);
		@(posedge clock);
		core <= 1'b1;
		pre <= 1'b1;
		// Start so that the strobe loads on a crystal tick
		@(negedge clock);
		if (!cyc[0])
			@(negedge clock);
		run(0, 16'h0010, 3'h1, 0, 2, 0);
		@(posedge clock);
		pre <= 1'b0;
		run(0, 16'h0011, 3'h1, 0, 1, 0);
		conclude;
	end
endmodule // test_emb_bus_cycles
